// ==== design/async_serial_params.svh ====
`ifndef ASYNC_SERIAL_PARAMS_SVH
`define ASYNC_SERIAL_PARAMS_SVH

// Register byte offsets (low address byte)
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_STATUS 8'h08
`define OFS_DATA 8'h0C
`define OFS_BAUD 8'h10
`define OFS_BREAK_CTRL 8'h14

// Control one fields
`define C1_LOOPBACK 7
`define C1_ENABLE 6
`define C1_INVERT 5
`define C1_NINE 4
`define C1_WAKE 3
`define C1_IDLE_TYPE 2
`define C1_PAR_EN 1
`define C1_PAR_ODD 0

// Control two fields
`define C2_TX_EMPTY_IE 7
`define C2_TX_DONE_IE 6
`define C2_RX_FULL_IE 5
`define C2_QUIET_IE 4
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_RWU 1

// Status fields
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_FRAME 1
`define ST_PARITY 0

// Break control field
`define BK_CLEAR_EN 0

// Reset values and frame lengths
`define RST_CTRL 8'h00
`define RST_BAUD 16'h0010
`define FRAME_LEN_EIGHT 4'hA
`define FRAME_LEN_NINE 4'hB

`endif

// ==== design/async_serial_pkg.sv ====
package async_serial_pkg;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_e;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_RUN = 1'b1} rx_state_e;
endpackage

// ==== design/async_serial_port_control.sv ====
// Operation
// - Stop freezes logic, keeps registers, masks requests.
// - Break clear on: clears in break work and stick.
// - Break clear off: break leaves flags; armed clear ends after.
// - Enabled: transmit pin is an output.
// - Enabled: receive pin is an input.
// - Loop-back feeds the receiver from the transmitter.
// - Disable sets empty and done, blocks transmit requests.
// - Inversion flips the transmitted level only; received levels are not inverted.
// - Nine or eight data bits; 11 or 10 bit frames.
// - Parity takes the top data position.
// - Parity odd when 1, even when 0.
// - Wake by address mark when 1, idle line when 0.
// - Idle ones count after stop when 1, start when 0.
// - Empty flag may request a transmit interrupt.
// - Done flag may request a transmit interrupt.
// - Full flag may request a receive interrupt.
// - Idle flag may request a receive interrupt.
// - Setting transmit on sends 10 or 11 ones.
// - Clearing transmit on finishes the character, then idles.
// - Clear then set mid-character queues an idle character.
// - Reset clears all control bits.
// - Transmit and receive on ignored while disabled.
`timescale 1ns/1ps
`include "async_serial_params.svh"

module async_serial_port_control #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Chip state
  input wire logic stop_mode,
  input wire logic debug_break,
  // General port logic behind the shared pins
  input wire logic port_tx_data,
  input wire logic port_tx_dir,
  input wire logic port_rx_data,
  input wire logic port_rx_dir,
  // Shared pins
  output logic tx_pin_out,
  output logic tx_pin_oe,
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq
);

  generate
    if (DIV_W < 4 || DIV_W > 32) begin : g_bad_width
      $error("DIV_W must lie between 4 and 32");
    end
  endgenerate

  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic break_clear_enable;
  logic [DIV_W-1:0] divisor;
  logic tx_empty_flag, tx_done_flag, rx_full_flag, rx_idle_flag, overrun_flag, frame_flag, parity_flag;
  logic [7:0] arm;
  logic [8:0] tx_buf, rx_data;
  logic wr_pend, rd_pend;
  logic [7:0] acc_addr;
  logic [31:0] read_value;
  async_serial_pkg::tx_state_e tx_state;
  async_serial_pkg::rx_state_e rx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic [DIV_W-1:0] tx_cnt, rx_cnt;
  logic tx_line, pend_pre;
  logic rx_s1, rx_s2, rx_s3, rx_filt;
  logic [9:0] rx_shift;
  logic [3:0] rx_bits, ones_cnt;
  logic idle_armed;

  // Decoded controls and access strobes
  logic enable, run, nine, take, wr_go, rd_go, clear_ok, clr_tx, clr_rx;
  logic tx_tick, rx_tick, tx_load_pre, tx_load_data, tx_rise, rx_src, rx_active;
  logic [3:0] frame_len;
  assign enable = ctrl_one[`C1_ENABLE];
  assign run = enable & ~stop_mode;
  assign nine = ctrl_one[`C1_NINE];
  assign frame_len = nine ? `FRAME_LEN_NINE : `FRAME_LEN_EIGHT;
  assign take = hsel & htrans[1] & hready;
  assign wr_go = wr_pend;
  assign rd_go = rd_pend;
  assign clear_ok = ~debug_break | break_clear_enable;
  assign clr_tx = wr_go & (acc_addr == `OFS_DATA) & clear_ok;
  assign clr_rx = rd_go & (acc_addr == `OFS_DATA) & clear_ok;
  assign hreadyout = ~rd_pend; // Reads take one wait state so a preceding write is seen
  assign hresp = 1'b0;

  // Frame builder; parity replaces the top data bit
  function automatic logic [10:0] build_frame(input logic [8:0] d, input logic n9, input logic parity_enable,
                                              input logic odd);
    logic [8:0] p;
    p = d;
    if (parity_enable && n9) begin
      p[8] = ^d[7:0] ^ odd;
    end else if (parity_enable) begin
      p[7] = ^d[6:0] ^ odd;
    end
    build_frame = n9 ? {1'b1, p, 1'b0} : {2'b11, p[7:0], 1'b0};
  endfunction

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      if (take) begin
        acc_addr <= haddr[7:0];
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (acc_addr)
      `OFS_CTRL_ONE: read_value[7:0] = ctrl_one;
      `OFS_CTRL_TWO: read_value[7:0] = ctrl_two;
      `OFS_STATUS: read_value[7:0] = {tx_empty_flag, tx_done_flag, rx_full_flag, rx_idle_flag,
                                      overrun_flag, 1'b0, frame_flag, parity_flag};
      `OFS_DATA: read_value[8:0] = rx_data;
      `OFS_BAUD: read_value[DIV_W-1:0] = divisor;
      `OFS_BREAK_CTRL: read_value[`BK_CLEAR_EN] = break_clear_enable;
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= read_value;
    end
  end

  // Control one, baud and break control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one <= `RST_CTRL;
      divisor <= DIV_W'(`RST_BAUD);
      break_clear_enable <= 1'b0;
    end else if (wr_go) begin
      if (acc_addr == `OFS_CTRL_ONE) begin
        ctrl_one <= hwdata[7:0];
      end
      if (acc_addr == `OFS_BAUD) begin
        divisor <= hwdata[DIV_W-1:0];
      end
      if (acc_addr == `OFS_BREAK_CTRL) begin
        break_clear_enable <= hwdata[`BK_CLEAR_EN];
      end
    end
  end

  // Control two; wake clears standby, a software write issued the same cycle wins
  logic wake_event;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_two <= `RST_CTRL;
    end else begin
      if (wake_event) begin
        ctrl_two[`C2_RWU] <= 1'b0;
      end
      if (wr_go && acc_addr == `OFS_CTRL_TWO) begin
        ctrl_two[7:4] <= hwdata[7:4];
        ctrl_two[`C2_RWU] <= hwdata[`C2_RWU];
        if (enable) begin
          ctrl_two[`C2_TX_ON] <= hwdata[`C2_TX_ON];
          ctrl_two[`C2_RX_ON] <= hwdata[`C2_RX_ON];
        end
      end
    end
  end
  assign tx_rise = wr_go & (acc_addr == `OFS_CTRL_TWO) & enable & hwdata[`C2_TX_ON] & ~ctrl_two[`C2_TX_ON];

  // Two-step clear arming; a status read during a protected break neither arms nor disarms
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm <= 8'h00;
    end else if (rd_go && acc_addr == `OFS_STATUS && clear_ok) begin
      arm <= read_value[7:0];
    end else begin
      if (clr_rx) begin
        arm[5:0] <= 6'h00;
      end
      if (clr_tx) begin
        arm[`ST_TX_EMPTY] <= 1'b0;
      end
    end
  end

  // Transmit buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf <= 9'h000;
    end else if (wr_go && acc_addr == `OFS_DATA) begin
      tx_buf <= hwdata[8:0];
    end
  end

  // Transmitter empty and done flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else if (!enable) begin
      tx_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      if (tx_load_data) begin
        tx_empty_flag <= 1'b1;
      end else if (clr_tx && arm[`ST_TX_EMPTY]) begin
        tx_empty_flag <= 1'b0;
      end
      tx_done_flag <= tx_empty_flag & ~pend_pre & (tx_state == async_serial_pkg::TX_IDLE);
    end
  end

  // Transmit bit-time divider, free running while the module runs
  assign tx_tick = run & (tx_cnt == '0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt <= '0;
    end else if (!enable) begin
      tx_cnt <= '0;
    end else if (run) begin
      tx_cnt <= tx_tick ? divisor : tx_cnt - 1'b1;
    end
  end

  // Preamble request; a set during a character queues the idle character behind it
  assign tx_load_pre = run & (tx_state == async_serial_pkg::TX_IDLE) & ctrl_two[`C2_TX_ON] & pend_pre;
  assign tx_load_data = run & (tx_state == async_serial_pkg::TX_IDLE) & ctrl_two[`C2_TX_ON] & ~pend_pre
                        & ~tx_empty_flag;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_pre <= 1'b0;
    end else if (!enable) begin
      pend_pre <= 1'b0;
    end else if (tx_rise) begin
      pend_pre <= 1'b1;
    end else if (tx_load_pre) begin
      pend_pre <= 1'b0;
    end
  end

  // Transmit shifter; a character in flight completes unless the module is disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= async_serial_pkg::TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_line <= 1'b1;
    end else if (!enable) begin
      tx_state <= async_serial_pkg::TX_IDLE;
      tx_line <= 1'b1;
    end else begin
      unique case (tx_state)
        async_serial_pkg::TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load_pre) begin
            tx_shift <= 11'h7FF;
            tx_left <= frame_len;
            tx_state <= async_serial_pkg::TX_SEND;
          end else if (tx_load_data) begin
            tx_shift <= build_frame(tx_buf, nine, ctrl_one[`C1_PAR_EN], ctrl_one[`C1_PAR_ODD]);
            tx_left <= frame_len;
            tx_state <= async_serial_pkg::TX_SEND;
          end
        end
        async_serial_pkg::TX_SEND: begin
          if (tx_tick && tx_left != 4'h0) begin
            tx_line <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left <= tx_left - 4'h1;
          end else if (tx_tick) begin
            tx_state <= async_serial_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // Shared pin ownership and inversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pin_out <= 1'b0;
      tx_pin_oe <= 1'b0;
      rx_pin_out <= 1'b0;
      rx_pin_oe <= 1'b0;
    end else begin
      tx_pin_out <= enable ? (tx_line ^ ctrl_one[`C1_INVERT]) : port_tx_data;
      tx_pin_oe <= enable | port_tx_dir;
      rx_pin_out <= port_rx_data;
      rx_pin_oe <= ~enable & port_rx_dir;
    end
  end

  // Receive pin synchroniser; a level counts once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_filt <= 1'b1;
    end else begin
      rx_s1 <= rx_pin_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_filt <= rx_s3;
      end
    end
  end

  // Receive source; loop-back takes the uninverted transmit line
  assign rx_src = ctrl_one[`C1_LOOPBACK] ? tx_line : rx_filt;
  assign rx_active = run & ctrl_two[`C2_RX_ON];
  assign rx_tick = rx_active & (rx_cnt == '0);

  // Receive sampler; mid-bit sampling from the start edge
  logic rx_done;
  assign rx_done = rx_tick & (rx_state == async_serial_pkg::RX_RUN) & (rx_bits == frame_len - 4'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= async_serial_pkg::RX_IDLE;
      rx_cnt <= '0;
      rx_bits <= 4'h0;
      rx_shift <= 10'h000;
    end else if (!enable || !ctrl_two[`C2_RX_ON]) begin
      rx_state <= async_serial_pkg::RX_IDLE;
      rx_cnt <= '0;
    end else if (run) begin
      rx_cnt <= rx_tick ? divisor : rx_cnt - 1'b1;
      unique case (rx_state)
        async_serial_pkg::RX_IDLE: begin
          if (!rx_src) begin
            rx_state <= async_serial_pkg::RX_RUN;
            rx_cnt <= divisor >> 1;
            rx_bits <= 4'h0;
          end
        end
        async_serial_pkg::RX_RUN: begin
          if (rx_tick) begin
            rx_bits <= rx_bits + 4'h1;
            rx_shift <= {rx_src, rx_shift[9:1]};
            if ((rx_bits == 4'h0 && rx_src) || rx_done) begin
              rx_state <= async_serial_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Received character assembly; eight-bit frames land one place higher
  logic [9:0] got;
  logic [8:0] got_data;
  logic got_par_bad;
  assign got = {rx_src, rx_shift[9:1]};
  assign got_data = nine ? got[8:0] : {1'b0, got[8:1]};
  assign got_par_bad = ctrl_one[`C1_PAR_EN] &
                       (got[8] != ((nine ? ^got[7:0] : ^got[7:1]) ^ ctrl_one[`C1_PAR_ODD]));

  // Idle counting of consecutive ones
  logic count_one, idle_event;
  assign count_one = rx_tick & rx_src & ((rx_state == async_serial_pkg::RX_IDLE) | rx_done |
                     ((rx_state == async_serial_pkg::RX_RUN) & ~ctrl_one[`C1_IDLE_TYPE]));
  assign idle_event = count_one & (ones_cnt == frame_len - 4'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ones_cnt <= 4'h0;
    end else if (!rx_active) begin
      ones_cnt <= ones_cnt;
    end else if (rx_tick && !rx_src) begin
      ones_cnt <= 4'h0;
    end else if (count_one && ones_cnt != frame_len) begin
      ones_cnt <= ones_cnt + 4'h1;
    end
  end

  // Standby wake events
  logic standby, accept, wake_mark;
  assign standby = ctrl_two[`C2_RWU];
  assign wake_mark = rx_done & standby & ctrl_one[`C1_WAKE] & got_data[nine ? 8 : 7];
  assign wake_event = wake_mark | (idle_event & standby & ~ctrl_one[`C1_WAKE]);
  assign accept = rx_done & (~standby | wake_mark);

  // Receive flags; a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_flag <= 1'b0;
      rx_idle_flag <= 1'b0;
      overrun_flag <= 1'b0;
      frame_flag <= 1'b0;
      parity_flag <= 1'b0;
      idle_armed <= 1'b0;
      rx_data <= 9'h000;
    end else begin
      if (clr_rx) begin
        rx_full_flag <= rx_full_flag & ~arm[`ST_RX_FULL];
        rx_idle_flag <= rx_idle_flag & ~arm[`ST_IDLE];
        overrun_flag <= overrun_flag & ~arm[`ST_OVERRUN];
        frame_flag <= frame_flag & ~arm[`ST_FRAME];
        parity_flag <= parity_flag & ~arm[`ST_PARITY];
      end
      if (accept && rx_full_flag && !(clr_rx && arm[`ST_RX_FULL])) begin
        overrun_flag <= 1'b1;
      end else if (accept) begin
        rx_data <= got_data;
        rx_full_flag <= 1'b1;
        idle_armed <= 1'b1;
        frame_flag <= (frame_flag & ~(clr_rx & arm[`ST_FRAME])) | ~got[9];
        parity_flag <= got_par_bad | (parity_flag & ~(clr_rx & arm[`ST_PARITY]));
      end
      if (idle_event && !standby && idle_armed) begin
        rx_idle_flag <= 1'b1;
        idle_armed <= 1'b0;
      end
    end
  end

  // Interrupt requests; stop mode holds them off so they cannot end it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= run & ((tx_empty_flag & ctrl_two[`C2_TX_EMPTY_IE]) |
                       (tx_done_flag & ctrl_two[`C2_TX_DONE_IE]));
      rx_irq <= ~stop_mode & ~standby & ((rx_full_flag & ctrl_two[`C2_RX_FULL_IE]) |
                                         (rx_idle_flag & ctrl_two[`C2_QUIET_IE]));
    end
  end

endmodule

// ==== testbench/async_serial_port_monitor.sv ====
`timescale 1ns/1ps
`include "async_serial_params.svh"

module async_serial_port_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Chip state and pins
  input wire logic stop_mode,
  input wire logic port_tx_data,
  input wire logic port_tx_dir,
  input wire logic port_rx_data,
  input wire logic port_rx_dir,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic rx_pin_out,
  input wire logic rx_pin_oe,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  logic take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic en_s;
  logic [3:0] ie_s;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Request accepted at this edge
  assign take = hsel & htrans[1] & hready;

  // Write address phase, so shadows land with the registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Shadow of module enable and interrupt enables, seen only from the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_s <= 1'b0;
      ie_s <= 4'h0;
    end else if (wr_pend) begin
      if (wr_addr == `OFS_CTRL_ONE) begin
        en_s <= hwdata[`C1_ENABLE];
      end
      if (wr_addr == `OFS_CTRL_TWO) begin
        ie_s <= hwdata[7:4];
      end
    end
  end

  a_tx_pin_drive: assert property ($past(en_s) && en_s |-> tx_pin_oe)
    else $error("tx pin not driven while enabled");
  a_port_tx_pass: assert property ($past(hresetn) && !$past(en_s) && !en_s
    |-> tx_pin_oe == $past(port_tx_dir) && tx_pin_out == $past(port_tx_data))
    else $error("tx pin not following port");
  a_rx_pin_input: assert property ($past(en_s) && en_s |-> !rx_pin_oe)
    else $error("rx pin driven while enabled");
  a_port_rx_pass: assert property ($past(hresetn) |-> rx_pin_out == $past(port_rx_data)
    && ($past(en_s) || rx_pin_oe == $past(port_rx_dir)))
    else $error("rx pin not following port");
  a_stop_quiet: assert property (stop_mode && $past(stop_mode) |-> !tx_irq && !rx_irq)
    else $error("request during stop");
  a_tx_irq_off: assert property (!en_s && !$past(en_s) |-> !tx_irq)
    else $error("tx request while disabled");
  a_tx_irq_cause: assert property (tx_irq |-> $past(ie_s[3]) || $past(ie_s[2]))
    else $error("tx request without enable");
  a_rx_irq_cause: assert property (rx_irq |-> $past(ie_s[1]) || $past(ie_s[0]))
    else $error("rx request without enable");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_wait_cause: assert property (!hreadyout |-> $past(take) && !$past(hwrite))
    else $error("wait without read");
  a_write_fast: assert property (take && hwrite |=> hreadyout && hresp == 1'b0)
    else $error("write stalled");
endmodule

// ==== testbench/remote_serial_model.sv ====
`timescale 1ns/1ps

module remote_serial_model #(
  parameter int BIT_CYC = 4
) (
  // Clock used only to time the bit cells
  input wire logic clk,
  // Line from the device and line back to it
  input wire logic line_in,
  output logic line_out
);
  // Idle high, as the pulled-up line would be
  initial line_out = 1'b1;

  // Hold the line at one level, used to jam the receive pin
  task automatic set_line(input logic v);
    @(posedge clk);
    line_out <= v;
  endtask

  // Start bit, data from the bottom bit up, one stop bit
  task automatic send_char(input logic [8:0] d, input int nb);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk);
      line_out <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  // Wait for a start edge, then sample each data cell and the stop cell in its middle
  task automatic get_frame(input int nb, input logic inv, output logic [8:0] d, output logic stop,
                           output int waited);
    d = 9'h000;
    waited = 0;
    while ((line_in ^ inv) !== 1'b0 && waited < 2000) begin
      @(posedge clk);
      waited++;
    end
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      d[i] = line_in ^ inv;
    end
    repeat (BIT_CYC) @(posedge clk);
    stop = line_in ^ inv;
  endtask
endmodule

// ==== testbench/async_serial_port_control_tb.sv ====
`timescale 1ns/1ps
`include "async_serial_params.svh"

module async_serial_port_control_tb;
  localparam int BIT_CYC = 4;
  logic hclk, hresetn, hsel, hwrite, stop_mode, debug_break, hready, rx_pin_in, tx_wire, remote_line;
  logic port_tx_data, port_tx_dir, port_rx_data, port_rx_dir, fstop;
  logic hreadyout, hresp, tx_pin_out, tx_pin_oe, rx_pin_out, rx_pin_oe, tx_irq, rx_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] fd, ex;
  logic [12:0] m;
  logic [12:0] modes [6];
  int error_cnt, total_checks, wcyc, nb;

  // Single slave, so its ready is the bus ready; undriven lines are pulled up
  assign hready = hreadyout;
  assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;
  assign rx_pin_in = rx_pin_oe ? rx_pin_out : remote_line;

  async_serial_port_control #(.DIV_W(16)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stop_mode(stop_mode), .debug_break(debug_break),
    .port_tx_data(port_tx_data), .port_tx_dir(port_tx_dir), .port_rx_data(port_rx_data),
    .port_rx_dir(port_rx_dir), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in),
    .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  remote_serial_model #(.BIT_CYC(BIT_CYC)) u_remote (.clk(hclk), .line_in(tx_wire), .line_out(remote_line));

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; the address is held until ready, read data taken with the second ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic read_reg(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    read_reg(a);
    chk(rd, exp);
  endtask

  // Poll status; the last read also arms the flags for clearing
  task automatic wait_rx_full;
    for (int i = 0; i < 300; i++) begin
      read_reg(`OFS_STATUS);
      if (rd[`ST_RX_FULL] === 1'b1) break;
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the sequence length
  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    {hresetn, hsel, hwrite, stop_mode, debug_break} = 5'h00;
    {port_tx_data, port_tx_dir, port_rx_data, port_rx_dir} = 4'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    error_cnt = 0;
    total_checks = 0;
    // nine, parity on, odd, invert, character
    modes = '{13'h005A, 13'h11A5, 13'h0813, 13'h0E13, 13'h1CF3, 13'h1AF3};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`OFS_CTRL_ONE, 32'h00000000);
    rchk(`OFS_CTRL_TWO, 32'h00000000);
    rchk(`OFS_STATUS, 32'h000000C0);
    rchk(8'h18, 32'h00000000);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h0000000C);
    rchk(`OFS_CTRL_TWO, 32'h00000000);
    {port_tx_data, port_tx_dir, port_rx_data, port_rx_dir} <= 4'hF;
    xfer(1'b1, `OFS_BAUD, 32'h00000003);
    xfer(1'b1, `OFS_CTRL_ONE, 32'h00000040);
    port_tx_dir <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({tx_pin_oe, rx_pin_oe}, 2'b10);
    // Six character formats, each opened by a fresh preamble
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      nb = m[12] ? 9 : 8;
      ex = m[8:0];
      if (!m[12]) ex[8] = 1'b0;
      if (m[11] && m[12]) ex[8] = ^ex[7:0] ^ m[10];
      if (m[11] && !m[12]) ex[7] = ^ex[6:0] ^ m[10];
      xfer(1'b1, `OFS_CTRL_ONE, {24'h000000, 2'b01, m[9], m[12], 2'b00, m[11], m[10]});
      xfer(1'b1, `OFS_CTRL_TWO, 32'h00000004);
      xfer(1'b1, `OFS_CTRL_TWO, 32'h0000000C);
      read_reg(`OFS_STATUS); // Arms the empty flag so the data write clears it
      xfer(1'b1, `OFS_DATA, {23'h000000, m[8:0]});
      u_remote.get_frame(nb, m[9], fd, fstop, wcyc);
      chk(wcyc >= (nb - 1) * BIT_CYC, 1'b1);
      chk({fstop, fd}, {1'b1, ex});
      repeat (3 * BIT_CYC) @(posedge hclk);
    end
    xfer(1'b1, `OFS_CTRL_ONE, 32'h00000040);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h0000002C);
    // Flag armed before break survives a data read inside it
    u_remote.send_char(9'h0A5, 8);
    wait_rx_full();
    chk(rx_irq, 1'b1);
    debug_break <= 1'b1;
    rchk(`OFS_DATA, 32'h000000A5);
    read_reg(`OFS_STATUS);
    chk(rd[`ST_RX_FULL], 1'b1);
    debug_break <= 1'b0;
    read_reg(`OFS_DATA);
    read_reg(`OFS_STATUS);
    chk({rd[`ST_RX_FULL], rx_irq}, 2'b00);
    // Clears inside break are allowed and stick
    xfer(1'b1, `OFS_BREAK_CTRL, 32'h00000001);
    u_remote.send_char(9'h03C, 8);
    wait_rx_full();
    debug_break <= 1'b1;
    read_reg(`OFS_STATUS);
    read_reg(`OFS_DATA);
    debug_break <= 1'b0;
    read_reg(`OFS_STATUS);
    chk(rd[`ST_RX_FULL], 1'b0);
    xfer(1'b1, `OFS_BREAK_CTRL, 32'h00000000);
    // Loop-back with the receive pin jammed low, both directions enabled
    xfer(1'b1, `OFS_CTRL_ONE, 32'h000000C0);
    u_remote.set_line(1'b0);
    xfer(1'b1, `OFS_DATA, 32'h00000096);
    wait_rx_full();
    read_reg(`OFS_DATA);
    chk(rd[8:0], 9'h096);
    u_remote.set_line(1'b1);
    xfer(1'b1, `OFS_CTRL_ONE, 32'h00000040);
    repeat (20) @(posedge hclk);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h000000CC);
    repeat (3) @(posedge hclk);
    chk(tx_irq, 1'b1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({tx_irq, rx_irq}, 2'b00);
    stop_mode <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(tx_irq, 1'b1);
    rchk(`OFS_CTRL_TWO, 32'h000000CC);
    xfer(1'b1, `OFS_CTRL_ONE, 32'h00000000);
    {port_tx_data, port_rx_data} <= 2'b00;
    repeat (3) @(posedge hclk);
    chk(tx_irq, 1'b0);
    read_reg(`OFS_STATUS);
    chk(rd[7:6], 2'b11);
    // Second reset in mid-run must clear nonzero controls
    xfer(1'b1, `OFS_CTRL_ONE, 32'h0000003F);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`OFS_CTRL_ONE, 32'h00000000);
    rchk(`OFS_CTRL_TWO, 32'h00000000);
    final_report();
  end
endmodule

bind async_serial_port_control async_serial_port_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .stop_mode(stop_mode), .port_tx_data(port_tx_data), .port_tx_dir(port_tx_dir),
  .port_rx_data(port_rx_data), .port_rx_dir(port_rx_dir), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
  .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
